//--- design/ucct_regs.sv
// Function
// [R01] Eight read/write common interrupt enable bits.
// [R02] Reset/babble and resume enables reset to one.
// [R03] Frame number read-only, upper bits zero.
// [R04] Four-bit endpoint select picks mapped bank.
// [R05] Software selects endpoint before indexed access.
// [R06] Forced host plus session enters host mode.
// [R07] Forced host held until session clears.
// [R08] Forced host speed from forced speed bits.
// [R09] Loopback bit moves packet, then self-clears.
// [R10] Forced full-speed settles on USB reset.
// [R11] Forced high-speed settles on USB reset.
// [R12] Test packet of 53 bytes sent repeatedly.
// [R13] Software loads test packet before mode.
// [R14] K test drives continuous K state.
// [R15] J test drives continuous J state.
// [R16] SE0/NAK test: high speed, NAK every IN.
// [R17] Max packet field, eleven bits, resets zero.
// [R18] Enabled flags interrupt; status read clears.
// [R19] Frame number updated with start-of-frame flag.
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`include "ucct_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ucct_regs
	import ucct_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// ----------------------------------------
	// Clock and reset
	// ----------------------------------------
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// ----------------------------------------
	// AXI4-Lite write channels
	// ----------------------------------------
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// ----------------------------------------
	// AXI4-Lite read channels
	// ----------------------------------------
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [31:0]       s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// ----------------------------------------
	// Link events from the protocol engine
	// ----------------------------------------
	input  wire logic [7:0]        irq_event,
	input  wire logic [10:0]       sof_frame_number,
	input  wire logic              session_active,
	input  wire logic              usb_reset_seen,
	input  wire logic              in_token_seen,
	input  wire logic              test_packet_byte_taken,
	input  wire logic              loopback_done,
	// ----------------------------------------
	// Controls toward the link and FIFOs
	// ----------------------------------------
	output var  logic              irq,
	output var  logic [3:0]        endpoint_bank_number,
	output var  logic [10:0]       packet_byte_limit,
	output var  logic              host_mode,
	output var  ucct_speed_t       link_speed,
	output var  ucct_line_t        line_drive,
	output var  logic              loopback_start,
	output var  logic              test_packet_active,
	output var  logic [5:0]        test_packet_index,
	output var  logic              nak_in_token
);

	initial begin
		if (ADDR_W < 5 || ADDR_W > 32) begin
			$error("ucct_regs: ADDR_W must lie between 5 and 32.");
		end
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0]  common_irq_enable;
	logic [7:0]  irq_status;
	logic [10:0] last_frame_count;
	logic [7:0]  compliance_test_control;
	logic        aw_held;
	logic        w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        loopback_busy;
	logic        forced_host_latch;
	ucct_speed_t speed_state;

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	wire         wr_fire   = aw_held && w_held && !s_axi_bvalid;
	wire [7:0]   wr_ofs    = {aw_addr[7:2], 2'b00};
	wire         wr_b0     = wr_fire && w_strb[0];
	wire         wr_b1     = wr_fire && w_strb[1];
	wire         hit_en_w  = (wr_ofs == `UCCT_OFS_IRQ_ENABLE);
	wire         hit_bank_w = (wr_ofs == `UCCT_OFS_BANK_SELECT);
	wire         hit_tm_w  = (wr_ofs == `UCCT_OFS_TEST_CONTROL);
	wire         hit_mxp_w = (wr_ofs == `UCCT_OFS_TX_MAXP);
	wire         wr_known  = hit_en_w || hit_bank_w || hit_tm_w || hit_mxp_w
		|| (wr_ofs == `UCCT_OFS_FRAME_COUNT) || (wr_ofs == `UCCT_OFS_IRQ_STATUS)
		|| (wr_ofs == `UCCT_OFS_LINK_STATUS);
	wire         wr_high_ok = (aw_addr[ADDR_W-1:2] >> 6) == '0;
	wire         tm_write  = wr_b0 && hit_tm_w && wr_high_ok;
	wire         loop_req  = tm_write && w_data[`UCCT_TM_LOOPBACK] && !loopback_busy;

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	wire         rd_fire   = s_axi_arvalid && s_axi_arready;
	wire [7:0]   rd_ofs    = {s_axi_araddr[7:2], 2'b00};
	wire         rd_high_ok = (s_axi_araddr[ADDR_W-1:2] >> 6) == '0;
	wire [7:0]   tm_read   = compliance_test_control & ~(8'h01 << `UCCT_TM_LOOPBACK);
	wire [7:0]   link_stat = {3'h0, loopback_busy, test_packet_active,
		speed_state, host_mode};
	logic [31:0] rd_value;
	logic        rd_ok;
	always_comb begin
		rd_value = 32'h0000_0000;
		rd_ok    = rd_high_ok;
		if (rd_ofs == `UCCT_OFS_IRQ_ENABLE) begin
			rd_value = {24'h00_0000, common_irq_enable};
		end else if (rd_ofs == `UCCT_OFS_FRAME_COUNT) begin
			rd_value = {21'h00_0000, last_frame_count};                  // [R03]
		end else if (rd_ofs == `UCCT_OFS_BANK_SELECT) begin
			rd_value = {28'h000_0000, endpoint_bank_number};
		end else if (rd_ofs == `UCCT_OFS_TEST_CONTROL) begin
			rd_value = {24'h00_0000, tm_read};
		end else if (rd_ofs == `UCCT_OFS_TX_MAXP) begin
			rd_value = {21'h00_0000, packet_byte_limit};                 // [R17]
		end else if (rd_ofs == `UCCT_OFS_IRQ_STATUS) begin
			rd_value = {24'h00_0000, irq_status};
		end else if (rd_ofs == `UCCT_OFS_LINK_STATUS) begin
			rd_value = {24'h00_0000, link_stat};
		end else begin
			rd_ok = 1'b0;
		end
	end
	wire         status_rd = rd_fire && rd_ok && (rd_ofs == `UCCT_OFS_IRQ_STATUS);

	// ----------------------------------------
	// Write channel handshake
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_known && wr_high_ok) ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Read channel handshake
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_value;
				s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			common_irq_enable       <= `UCCT_RST_IRQ_ENABLE;               // [R02]
			endpoint_bank_number    <= `UCCT_RST_BANK_SELECT;
			compliance_test_control <= `UCCT_RST_TEST_CONTROL;
			packet_byte_limit       <= `UCCT_RST_TX_MAXP;                  // [R17]
		end else begin
			if (wr_b0 && hit_en_w && wr_high_ok) begin
				common_irq_enable <= w_data[7:0];                          // [R01]
			end
			if (wr_b0 && hit_bank_w && wr_high_ok) begin
				endpoint_bank_number <= w_data[3:0];                       // [R04] [R05]
			end
			if (tm_write) begin
				compliance_test_control <= w_data[7:0]
					& ~(8'h01 << `UCCT_TM_LOOPBACK);                       // [R09]
			end
			if (wr_b0 && hit_mxp_w && wr_high_ok) begin
				packet_byte_limit[7:0] <= w_data[7:0];
			end
			if (wr_b1 && hit_mxp_w && wr_high_ok) begin
				packet_byte_limit[10:8] <= w_data[10:8];                   // [R17]
			end
		end
	end

	// ----------------------------------------
	// Interrupt status and frame capture
	// ----------------------------------------
	// A new event in the cycle of a status read survives the clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status       <= 8'h00;
			last_frame_count <= 11'h000;
			irq              <= 1'b0;
		end else begin
			irq_status <= (status_rd ? 8'h00 : irq_status) | irq_event;    // [R18]
			if (irq_event[`UCCT_IRQ_SOF]) begin
				last_frame_count <= sof_frame_number;                      // [R19]
			end
			irq <= |(((status_rd ? 8'h00 : irq_status) | irq_event)
				& common_irq_enable);                                       // [R18]
		end
	end

	// ----------------------------------------
	// Loopback, forced host and speed
	// ----------------------------------------
	// The loopback bit is held internally until the FIFO side reports the move.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			loopback_start    <= 1'b0;
			loopback_busy     <= 1'b0;
			forced_host_latch <= 1'b0;
			host_mode         <= 1'b0;
			speed_state       <= UCCT_SPEED_NEG;
		end else begin
			loopback_start <= loop_req;                                    // [R09]
			if (loop_req) begin
				loopback_busy <= 1'b1;
			end else if (loopback_done) begin
				loopback_busy <= 1'b0;                                     // [R09]
			end
			if (!session_active) begin
				forced_host_latch <= 1'b0;                                 // [R07]
			end else if (compliance_test_control[`UCCT_TM_FORCE_HOST]) begin
				forced_host_latch <= 1'b1;                                 // [R06] [R07]
			end
			host_mode <= session_active
				&& (forced_host_latch || compliance_test_control[`UCCT_TM_FORCE_HOST]);
			if (compliance_test_control[`UCCT_TM_IDLE_NAK]) begin
				speed_state <= UCCT_SPEED_HIGH;                            // [R16]
			end else if (forced_host_latch || usb_reset_seen) begin
				if (compliance_test_control[`UCCT_TM_PIN_HS]) begin
					speed_state <= UCCT_SPEED_HIGH;                        // [R08] [R11]
				end else if (compliance_test_control[`UCCT_TM_PIN_FS]) begin
					speed_state <= UCCT_SPEED_FULL;                        // [R08] [R10]
				end else if (usb_reset_seen) begin
					speed_state <= UCCT_SPEED_NEG;
				end
			end
		end
	end
	always_comb link_speed = speed_state;

	// ----------------------------------------
	// Line test modes
	// ----------------------------------------
	// Only one line mode may drive at once; the lowest-numbered set bit wins.
	wire         tp_on    = compliance_test_control[`UCCT_TM_TEST_PACKET];
	wire [5:0]   tp_last  = `UCCT_TEST_PACKET_BYTES - 6'd1;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_drive         <= UCCT_LINE_NORMAL;
			test_packet_active <= 1'b0;
			test_packet_index  <= 6'h00;
			nak_in_token       <= 1'b0;
		end else begin
			if (compliance_test_control[`UCCT_TM_IDLE_NAK]) begin
				line_drive <= UCCT_LINE_NAK;
			end else if (compliance_test_control[`UCCT_TM_TEST_J]) begin
				line_drive <= UCCT_LINE_J;                                 // [R15]
			end else if (compliance_test_control[`UCCT_TM_TEST_K]) begin
				line_drive <= UCCT_LINE_K;                                 // [R14]
			end else if (tp_on) begin
				line_drive <= UCCT_LINE_PACKET;                            // [R12] [R13]
			end else begin
				line_drive <= UCCT_LINE_NORMAL;
			end
			test_packet_active <= tp_on;
			if (!tp_on) begin
				test_packet_index <= 6'h00;
			end else if (test_packet_byte_taken) begin
				test_packet_index <= (test_packet_index == tp_last)
					? 6'h00 : test_packet_index + 6'h01;                   // [R12]
			end
			nak_in_token <= compliance_test_control[`UCCT_TM_IDLE_NAK]
				&& in_token_seen;                                          // [R16]
		end
	end

endmodule : ucct_regs

`default_nettype wire

//--- design/ucct_map.svh
`ifndef UCCT_MAP_SVH
`define UCCT_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define UCCT_OFS_IRQ_ENABLE   8'h00
`define UCCT_OFS_FRAME_COUNT  8'h04
`define UCCT_OFS_BANK_SELECT  8'h08
`define UCCT_OFS_TEST_CONTROL 8'h0C
`define UCCT_OFS_TX_MAXP      8'h10
`define UCCT_OFS_IRQ_STATUS   8'h14
`define UCCT_OFS_LINK_STATUS  8'h18

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UCCT_RST_IRQ_ENABLE   8'h06
`define UCCT_RST_BANK_SELECT  4'h0
`define UCCT_RST_TEST_CONTROL 8'h00
`define UCCT_RST_TX_MAXP      11'h000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UCCT_IRQ_SUPPLY_FAULT 7
`define UCCT_IRQ_LINK_REQUEST 6
`define UCCT_IRQ_DETACH       5
`define UCCT_IRQ_ATTACH       4
`define UCCT_IRQ_SOF          3
`define UCCT_IRQ_RESET_BABBLE 2
`define UCCT_IRQ_RESUME       1
`define UCCT_IRQ_SUSPEND      0

`define UCCT_TM_FORCE_HOST    7
`define UCCT_TM_LOOPBACK      6
`define UCCT_TM_PIN_FS        5
`define UCCT_TM_PIN_HS        4
`define UCCT_TM_TEST_PACKET   3
`define UCCT_TM_TEST_K        2
`define UCCT_TM_TEST_J        1
`define UCCT_TM_IDLE_NAK      0

// ----------------------------------------
// Test packet length in bytes
// ----------------------------------------
`define UCCT_TEST_PACKET_BYTES 6'd53

`endif

//--- design/ucct_pkg.sv
package ucct_pkg;

	typedef enum logic [1:0] {
		UCCT_SPEED_FULL = 2'b00,
		UCCT_SPEED_HIGH = 2'b01,
		UCCT_SPEED_NEG  = 2'b10
	} ucct_speed_t;

	typedef enum logic [2:0] {
		UCCT_LINE_NORMAL = 3'b000,
		UCCT_LINE_K      = 3'b001,
		UCCT_LINE_J      = 3'b010,
		UCCT_LINE_PACKET = 3'b011,
		UCCT_LINE_NAK    = 3'b100
	} ucct_line_t;

	typedef enum logic [1:0] {
		UCCT_ROLE_IDLE = 2'b00,
		UCCT_ROLE_HOST = 2'b01,
		UCCT_ROLE_PERI = 2'b10
	} ucct_role_t;

endpackage : ucct_pkg

//--- sim/ucct_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port watcher
// ----------------------------------------
module ucct_regs_checker
	import ucct_pkg::*;
(
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Bus and link inputs
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_arvalid,
	input wire logic [7:0] irq_event,
	input wire logic       session_active,
	input wire logic       in_token_seen,
	input wire logic       test_packet_byte_taken,
	// Block outputs
	input wire logic       irq,
	input wire logic       host_mode,
	input wire ucct_line_t line_drive,
	input wire logic       loopback_start,
	input wire logic       test_packet_active,
	input wire logic [5:0] test_packet_index,
	input wire logic       nak_in_token
);
	// Mask writes move irq too, so they count as causes beside events and status reads.
	wire logic raise_cause = (|irq_event) || s_axi_wvalid;
	wire logic drop_cause  = s_axi_arvalid || s_axi_wvalid;
	wire logic pkt_step    = test_packet_active && test_packet_byte_taken;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_nak_req;
		in_token_seen && line_drive == UCCT_LINE_NAK;
	endsequence
	sequence s_one_pulse;
		loopback_start ##1 !loopback_start;
	endsequence

	nak_answer_a: assert property (s_nak_req |=> nak_in_token)
		else $error("IN token not refused");
	nak_cause_a: assert property (nak_in_token |-> $past(in_token_seen))
		else $error("refusal without IN token");
	loop_pulse_a: assert property (loopback_start |-> s_one_pulse)
		else $error("loopback start too long");
	pkt_range_a: assert property (test_packet_index <= 6'h34)
		else $error("packet index out of range");
	pkt_wrap_a: assert property (pkt_step && test_packet_index == 6'h34
		|=> test_packet_index == 6'h00 || !test_packet_active)
		else $error("packet index did not wrap");
	pkt_step_a: assert property (pkt_step && test_packet_index < 6'h34
		|=> test_packet_index == $past(test_packet_index) + 6'h01 || !test_packet_active)
		else $error("packet index did not step");
	host_rise_a: assert property ($rose(host_mode) |-> $past(session_active))
		else $error("host mode without session");
	host_hold_a: assert property (host_mode && session_active |=> host_mode)
		else $error("host mode left during session");
	irq_rise_a: assert property ($rose(irq) |->
		$past(raise_cause) || $past(raise_cause, 2) || $past(raise_cause, 3))
		else $error("irq rose without cause");
	irq_drop_a: assert property ($fell(irq) |->
		$past(drop_cause) || $past(drop_cause, 2) || $past(drop_cause, 3))
		else $error("irq fell without cause");
endmodule : ucct_regs_checker

bind ucct_regs ucct_regs_checker u_ucct_regs_checker (
	.aclk, .aresetn, .s_axi_wvalid, .s_axi_arvalid, .irq_event, .session_active,
	.in_token_seen, .test_packet_byte_taken, .irq, .host_mode, .line_drive,
	.loopback_start, .test_packet_active, .test_packet_index, .nak_in_token
);
`default_nettype wire

//--- sim/ucct_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module ucct_link_model (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Requests from the block
	input  wire logic loopback_start,
	input  wire logic test_packet_active,
	// Link answers
	output var  logic test_packet_byte_taken,
	output var  logic loopback_done
);
	logic [2:0] lb_wait;

	// Bytes are taken every other cycle, so the index is seen to stall as well as step.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lb_wait                <= 3'h0;
			test_packet_byte_taken <= 1'h0;
			loopback_done          <= 1'h0;
		end else begin
			test_packet_byte_taken <= test_packet_active && !test_packet_byte_taken;
			lb_wait                <= loopback_start ? 3'h4 : lb_wait - 3'(lb_wait != 3'h0);
			loopback_done          <= lb_wait == 3'h1;
		end
	end
endmodule : ucct_link_model
`default_nettype wire

//--- sim/ucct_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ucct_regs_bench
	import ucct_pkg::*;
();
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, irq_event = 8'h00;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        session_active = 1'h0, usb_reset_seen = 1'h0, in_token_seen = 1'h0;
	logic [10:0] sof_frame_number = 11'h000;
	wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic   irq, host_mode, loopback_start, test_packet_active, nak_in_token;
	wire logic   test_packet_byte_taken, loopback_done;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [3:0]  endpoint_bank_number;
	wire logic [10:0] packet_byte_limit;
	wire logic [5:0]  test_packet_index;
	wire ucct_speed_t link_speed;
	wire ucct_line_t  line_drive;
	int error_cnt = 0, checks_done = 0, lb_cnt = 0, nak_cnt = 0;

	ucct_regs u_ucct_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .irq_event, .sof_frame_number, .session_active, .usb_reset_seen,
		.in_token_seen, .test_packet_byte_taken, .loopback_done, .irq, .endpoint_bank_number,
		.packet_byte_limit, .host_mode, .link_speed, .line_drive, .loopback_start,
		.test_packet_active, .test_packet_index, .nak_in_token);
	ucct_link_model u_ucct_link_model (.aclk, .aresetn, .loopback_start,
		.test_packet_active, .test_packet_byte_taken, .loopback_done);

	always #4 aclk = ~aclk;
	// Pulses are counted here because they can come and go inside a bus cycle.
	always @(posedge aclk) begin
		lb_cnt <= lb_cnt + int'(loopback_start);
		nak_cnt <= nak_cnt + int'(nak_in_token);
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw_done = 1'h0;
		bit w_done = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'h0;
				aw_done = 1'h1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'h0;
				w_done = 1'h1;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : rd

	task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
		logic [1:0] r;
		wr(a, d, r);
		chk(32'(r), 32'(e));
	endtask : wchk

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re = 2'h0);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
		chk(32'(r), 32'(re));
	endtask : rchk

	task automatic ev(input logic [7:0] e, input logic [10:0] f);
		@(posedge aclk);
		irq_event <= e;
		sof_frame_number <= f;
		@(posedge aclk);
		irq_event <= 8'h00;
	endtask : ev

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		logic [1:0] r;
		rchk(8'h00, 32'h06);
		rchk(8'h04, 32'h0);
		rchk(8'h08, 32'h0);
		rchk(8'h10, 32'h0);
		rchk(8'h1C, 32'h0, 2'h2);
		wchk(8'h1C, 32'hFF, 2'h2);
		wchk(8'h00, 32'hFF);
		rchk(8'h00, 32'hFF);
		wchk(8'h08, 32'hFF);
		rchk(8'h08, 32'h0F);
		chk(32'(endpoint_bank_number), 32'hF);
		wchk(8'h10, 32'hFFFF);
		rchk(8'h10, 32'h7FF);
		chk(32'(packet_byte_limit), 32'h7FF);
		wr(8'h04, 32'h7FF, r);
		rchk(8'h04, 32'h0);
	endtask : t_regs

	task automatic t_irq;
		for (int i = 0; i < 8; i++) begin
			wchk(8'h00, 32'h1 << i);
			ev(8'h1 << i, 11'h7F8 + 11'(i));
			repeat (3) @(posedge aclk);
			chk(32'(irq), 32'h1);
			rchk(8'h14, 32'h1 << i);
			repeat (3) @(posedge aclk);
			chk(32'(irq), 32'h0);
		end
		rchk(8'h04, 32'h7FB);
		wchk(8'h00, 32'hFE);
		ev(8'h01, 11'h000);
		repeat (3) @(posedge aclk);
		chk(32'(irq), 32'h0);
		rchk(8'h14, 32'h01);
		rchk(8'h04, 32'h7FB);
	endtask : t_irq

	task automatic t_modes;
		logic [7:0] m [5] = '{8'h04, 8'h02, 8'h01, 8'h0F, 8'h08};
		ucct_line_t l [5] = '{UCCT_LINE_K, UCCT_LINE_J, UCCT_LINE_NAK, UCCT_LINE_NAK,
			UCCT_LINE_PACKET};
		for (int i = 0; i < 5; i++) begin
			wchk(8'h0C, 32'(m[i]));
			rchk(8'h0C, 32'(m[i]));
			chk(32'(line_drive), 32'(l[i]));
			@(posedge aclk);
			in_token_seen <= 1'h1;
			@(posedge aclk);
			in_token_seen <= 1'h0;
			repeat (3) @(posedge aclk);
			chk(32'(nak_cnt), (i == 2 || i == 3) ? i - 1 : (i < 2 ? 0 : 2));
		end
		repeat (120) @(posedge aclk);
		chk(32'(test_packet_active), 32'h1);
		wchk(8'h0C, 32'h0);
	endtask : t_modes

	task automatic t_host;
		logic [7:0] m [2] = '{8'h90, 8'hB0};
		for (int i = 0; i < 2; i++) begin
			wchk(8'h0C, 32'(m[i]));
			@(posedge aclk);
			session_active <= 1'h1;
			repeat (4) @(posedge aclk);
			chk(32'(host_mode), 32'h1);
			chk(32'(link_speed), 32'(UCCT_SPEED_HIGH));
			ev(8'h20, 11'h000);
			repeat (4) @(posedge aclk);
			chk(32'(host_mode), 32'h1);
			session_active <= 1'h0;
			repeat (4) @(posedge aclk);
			chk(32'(host_mode), 32'h0);
		end
		rchk(8'h14, 32'h20);
		wchk(8'h0C, 32'h0);
	endtask : t_host

	task automatic t_speed;
		logic [7:0] m [3] = '{8'h20, 8'h10, 8'h00};
		ucct_speed_t s [3] = '{UCCT_SPEED_FULL, UCCT_SPEED_HIGH, UCCT_SPEED_NEG};
		for (int i = 0; i < 3; i++) begin
			wchk(8'h0C, 32'(m[i]));
			@(posedge aclk);
			usb_reset_seen <= 1'h1;
			@(posedge aclk);
			usb_reset_seen <= 1'h0;
			repeat (3) @(posedge aclk);
			chk(32'(link_speed), 32'(s[i]));
		end
	endtask : t_speed

	task automatic t_loop;
		rchk(8'h18, 32'h04);
		wchk(8'h0C, 32'h40);
		repeat (10) @(posedge aclk);
		chk(32'(lb_cnt), 32'h1);
		rchk(8'h0C, 32'h0);
	endtask : t_loop

	task automatic print_verdict;
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs;
		t_irq;
		t_modes;
		t_host;
		t_speed;
		t_loop;
		print_verdict;
	end

	initial begin
		repeat (25000) @(posedge aclk);
		error_cnt++;
		print_verdict;
	end
endmodule : ucct_regs_bench
`default_nettype wire
